// *** hdl/bpsq_pkg.sv ***
// package: shared constants and carriers for the protection sequencer
package bpsq_pkg;
   localparam int unsigned OVL_WAIT_CYCLES   = 512;
   localparam int unsigned OVL_HICCUP_CYCLES = 16384;
   localparam int unsigned THM_HICCUP_CYCLES = 16384;
   localparam int unsigned CNT_W             = 15;

   // comparator indications from the analog front end
   typedef struct packed {
      logic overvoltage_guard;
      logic peak_reached;
      logic ls_source_limit;
      logic ls_sink_limit;
      logic overload;
      logic over_temp;
      logic ss_discharged;
      logic sense_in_window;
   } bpsq_cmp_t;

   // gate commands to the drivers
   typedef struct packed {
      logic hs_on;
      logic ls_on;
   } bpsq_gate_t;

   typedef enum logic [4:0] {
      BPSQ_DISCHARGE = 5'h01,
      BPSQ_RUN       = 5'h02,
      BPSQ_OVL_OFF   = 5'h04,
      BPSQ_THM_HOT   = 5'h08,
      BPSQ_THM_COOL  = 5'h10
   } bpsq_state_t;
endpackage : bpsq_pkg

// *** hdl/bpsq_sync.sv ***
// file: three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module bpsq_sync #(
   parameter int unsigned W = 8
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
      end else begin
         s1 <= din;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // a change counts once stages two and three agree
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dout <= '0;
      end else begin
         for (int i = 0; i < W; i++) begin
            if (s2[i] == s3[i]) begin
               dout[i] <= s3[i];
            end
         end
      end
   end
endmodule : bpsq_sync
`default_nettype wire

// *** hdl/bpsq_top.sv ***
// file: cycle-based switch protection sequencer for a buck stage
// How it works
// - overvoltage holds high-side switch off
// - high-side returns only at next cycle
// - peak-current event ends high-side pulse
// - peak event turns low-side on same cycle
// - sourcing limit at cycle end skips pulse
// - pulses resume when cycle starts below limit
// - sinking limit kills low-side immediately
// - after sink trip both off until cycle
// - overload over 512 cycles shuts down
// - overload shutdown lasts 16384 cycles, restarts
// - over-temperature stops all switching
// - thermal count starts once temperature releases
// - thermal count 16384 reruns power-up
// - wait for soft-start discharge before switching
// - output good low during thermal shutdown
`timescale 1ns/10ps
`default_nettype none
module bpsq_top
   import bpsq_pkg::*;
#(
   parameter int unsigned OVL_WAIT = bpsq_pkg::OVL_WAIT_CYCLES,
   parameter int unsigned OVL_HIC  = bpsq_pkg::OVL_HICCUP_CYCLES,
   parameter int unsigned THM_HIC  = bpsq_pkg::THM_HICCUP_CYCLES
) (
   input  wire logic                clk,
   input  wire logic                rst,
   input  wire logic                cycle_tick,
   input  wire bpsq_pkg::bpsq_cmp_t cmp_in,
   output bpsq_pkg::bpsq_gate_t     gate,
   output logic                     ss_discharge,
   output logic                     output_good_flag
);
   import bpsq_pkg::*;

   bpsq_cmp_t   cmp;
   logic        tick;
   logic        tick_s1;
   bpsq_state_t state;
   bpsq_state_t next_state;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] ovl_cnt;
   logic        hs_done;
   logic        sink_trip;
   logic        src_skip;

   // ------------------------------------------------------------
   // input conditioning
   // ------------------------------------------------------------
   bpsq_sync #(.W($bits(bpsq_cmp_t))) u_sync (
      .clk  (clk),
      .rst  (rst),
      .din  (cmp_in),
      .dout (cmp)
   );

   // oscillator edge to one-cycle tick
   bpsq_sync #(.W(1)) u_tick (
      .clk  (clk),
      .rst  (rst),
      .din  (cycle_tick),
      .dout (tick_s1)
   );
   logic tick_d;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tick_d <= 1'b0;
      end else begin
         tick_d <= tick_s1;
      end
   end
   assign tick = tick_s1 & ~tick_d;

   // ------------------------------------------------------------
   // sequencing state
   // ------------------------------------------------------------
   always_comb begin
      next_state = state;
      case (state)
         BPSQ_DISCHARGE: begin
            if (tick && cmp.ss_discharged) begin
               next_state = BPSQ_RUN;
            end
         end
         BPSQ_RUN: begin
            if (tick && ovl_cnt >= CNT_W'(OVL_WAIT)) begin
               next_state = BPSQ_OVL_OFF;
            end
         end
         BPSQ_OVL_OFF: begin
            if (tick && cnt >= CNT_W'(OVL_HIC - 1)) begin
               next_state = BPSQ_DISCHARGE;
            end
         end
         BPSQ_THM_HOT: begin
            if (!cmp.over_temp) begin
               next_state = BPSQ_THM_COOL;
            end
         end
         BPSQ_THM_COOL: begin
            if (cmp.over_temp) begin
               next_state = BPSQ_THM_HOT;
            end else if (tick && cnt >= CNT_W'(THM_HIC - 1)) begin
               next_state = BPSQ_DISCHARGE;
            end
         end
         default: next_state = BPSQ_DISCHARGE;
      endcase
      if (cmp.over_temp) begin
         next_state = BPSQ_THM_HOT;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= BPSQ_DISCHARGE;
      end else begin
         state <= next_state;
      end
   end

   // hiccup counter, cleared on every state change
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt <= '0;
      end else if (next_state != state) begin
         cnt <= '0;
      end else if (tick) begin
         cnt <= cnt + 1'b1;
      end
   end

   // overload persistence counter
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ovl_cnt <= '0;
      end else if (state != BPSQ_RUN || !cmp.overload) begin
         ovl_cnt <= '0;
      end else if (tick && ovl_cnt < CNT_W'(OVL_WAIT)) begin
         ovl_cnt <= ovl_cnt + 1'b1;
      end
   end

   // ------------------------------------------------------------
   // per-cycle switch decisions
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         src_skip <= 1'b0;
      end else if (tick) begin
         src_skip <= cmp.ls_source_limit;
      end
   end

   // set wins over the cycle-start clear, so no pulse starts mid cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hs_done <= 1'b1;
      end else if (cmp.peak_reached || cmp.overvoltage_guard
                   || state != BPSQ_RUN) begin
         hs_done <= 1'b1;
      end else if (tick) begin
         hs_done <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sink_trip <= 1'b0;
      end else if (cmp.ls_sink_limit) begin
         sink_trip <= 1'b1;
      end else if (tick) begin
         sink_trip <= 1'b0;
      end
   end

   logic run_ok;
   logic next_hs;
   logic next_ls;
   always_comb begin
      run_ok  = (state == BPSQ_RUN) && (next_state == BPSQ_RUN);
      next_hs = run_ok && !hs_done && !cmp.peak_reached
                && !cmp.overvoltage_guard && !src_skip
                && !sink_trip;
      next_ls = run_ok && !next_hs && !sink_trip
                && !cmp.ls_sink_limit;
      if (tick) begin
         next_hs = run_ok && !cmp.overvoltage_guard
                   && !cmp.ls_source_limit && !cmp.peak_reached
                   && !cmp.ls_sink_limit;
         next_ls = run_ok && !next_hs
                   && !cmp.ls_sink_limit;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         gate <= '0;
      end else begin
         gate.hs_on <= next_hs;
         gate.ls_on <= next_ls;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ss_discharge     <= 1'b1;
         output_good_flag <= 1'b0;
      end else begin
         ss_discharge     <= (next_state != BPSQ_RUN);
         output_good_flag <= (next_state == BPSQ_RUN)
                             && cmp.sense_in_window
                             && !cmp.over_temp;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   a_ovp_hs_off: assert property (@(posedge clk) disable iff (rst)
      cmp.overvoltage_guard |=> !gate.hs_on)
      else $error("high side on during overvoltage");

   a_ovp_wait_tick: assert property (@(posedge clk) disable iff (rst)
      (!gate.hs_on && !tick) |=> !gate.hs_on || $past(tick, 1))
      else $error("high side reenabled mid cycle");

   a_peak_off: assert property (@(posedge clk) disable iff (rst)
      (cmp.peak_reached && !tick) |=> !gate.hs_on)
      else $error("high side on after peak");

   a_peak_pair: assert property (@(posedge clk) disable iff (rst)
      (gate.hs_on && cmp.peak_reached && !tick && !cmp.ls_sink_limit
       && !cmp.over_temp && state == BPSQ_RUN) |=> gate.ls_on)
      else $error("low side not on after peak");

   a_src_skip: assert property (@(posedge clk) disable iff (rst)
      (tick && cmp.ls_source_limit) |=> !gate.hs_on)
      else $error("pulse not skipped on sourcing limit");

   a_sink_off: assert property (@(posedge clk) disable iff (rst)
      (cmp.ls_sink_limit && !tick)
      |=> !gate.ls_on ##1 (!gate.ls_on || $past(tick, 1)))
      else $error("low side on after sink trip");

   a_sink_both: assert property (@(posedge clk) disable iff (rst)
      (sink_trip && !tick) |=> !gate.hs_on && !gate.ls_on)
      else $error("switch on after sink trip");

   a_thm_stop: assert property (@(posedge clk) disable iff (rst)
      cmp.over_temp |=> !gate.hs_on && !gate.ls_on && !output_good_flag)
      else $error("switching during over temperature");

   a_ovl_clear: assert property (@(posedge clk) disable iff (rst)
      (!cmp.overload) |=> ovl_cnt == '0)
      else $error("overload count not cleared");

   a_dis_wait: assert property (@(posedge clk) disable iff (rst)
      (state == BPSQ_DISCHARGE) |=> !gate.hs_on && !gate.ls_on)
      else $error("switching before discharge");
endmodule : bpsq_top
`default_nettype wire

// *** sim/bpsq_partner.sv ***
// file: behavioural power stage and comparator model
`timescale 1ns/10ps
`default_nettype none
module bpsq_partner
   import bpsq_pkg::*;
#(
   parameter int unsigned PER  = 40,
   parameter int unsigned RAMP = 12
) (
   input  wire logic                 clk,
   input  wire logic                 rst,
   input  wire bpsq_pkg::bpsq_cmp_t  flt,
   input  wire bpsq_pkg::bpsq_gate_t gate,
   input  wire logic                 ss_discharge,
   output logic                      cycle_tick,
   output bpsq_pkg::bpsq_cmp_t       cmp_in
);
   int ph;
   int rmp;
   int ss;
   // oscillator, square wave of PER clocks
   always_ff @(posedge clk or posedge rst) begin
      if (rst) ph <= 0;
      else ph <= (ph == PER - 1) ? 0 : ph + 1;
   end
   assign cycle_tick = ph < PER / 2;
   // switch current ramps while high side on; soft-start node drains
   always_ff @(posedge clk) begin
      rmp <= gate.hs_on ? rmp + 1 : 0;
      ss  <= ss_discharge ? ss + 1 : 0;
   end
   always_comb begin
      cmp_in               = flt;
      cmp_in.peak_reached  = flt.peak_reached | (rmp >= RAMP);
      cmp_in.ss_discharged = ss > 60;
   end
endmodule : bpsq_partner
`default_nettype wire

// *** sim/bpsq_bench.sv ***
// file: self-checking bench for the protection sequencer
`timescale 1ns/10ps
`default_nettype none
module bpsq_bench;
   import bpsq_pkg::*;
   localparam int PER = 40;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        tick;
   bpsq_cmp_t   flt = 8'h01;
   bpsq_cmp_t   cmp;
   bpsq_gate_t  gate;
   logic        ssd;
   logic        good;
   logic [15:0] hs;
   logic [15:0] ls;
   logic [15:0] k;
   int          errors;
   int          cmp_count;
   int          cyc;

   initial forever #50 clk = ~clk;

   bpsq_top #(.OVL_WAIT(4), .OVL_HIC(8), .THM_HIC(8)) u_dut (
      .clk(clk), .rst(rst), .cycle_tick(tick), .cmp_in(cmp),
      .gate(gate), .ss_discharge(ssd), .output_good_flag(good));
   bpsq_partner #(.PER(PER), .RAMP(12)) u_pwr (
      .clk(clk), .rst(rst), .flt(flt), .gate(gate),
      .ss_discharge(ssd), .cycle_tick(tick), .cmp_in(cmp));

   task automatic chk(input string what, input logic [15:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s exp %0h seen %0h", what, exp, seen);
      end
   endtask : chk
   task automatic clks(input int n);
      repeat (n) @(posedge clk);
   endtask : clks
   // count clocks with each gate high over a window
   task automatic watch(input int n);
      hs = '0;
      ls = '0;
      repeat (n) begin
         @(posedge clk);
         hs += 16'(gate.hs_on === 1'b1);
         ls += 16'(gate.ls_on === 1'b1);
      end
   endtask : watch
   task automatic wait_hs(input logic v);
      k = '0;
      while (gate.hs_on !== v && k < 2 * PER) begin
         @(posedge clk);
         k++;
      end
   endtask : wait_hs
   task automatic complete_run;
      $display("errors %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : complete_run
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         complete_run();
      end
   end
   //----------------------------------------
   // scenarios
   //----------------------------------------
   task automatic test_start;
      clks(10);
      rst <= 1'b0;
      @(negedge clk);
      chk("reset gates", gate, 2'h0);
      chk("reset discharge", ssd, 1'h1);
      watch(45);
      chk("idle before discharge", hs + ls, 0);
      clks(4 * PER);
      chk("running", {ssd, good}, 2'h1);
      $display("test start done");
   endtask : test_start
   task automatic test_pulse;
      wait_hs(1'b0);
      wait_hs(1'b1);
      wait_hs(1'b0);
      chk("pulse ends at peak", 16'(k >= 12 && k <= 20), 1);
      chk("low side follows", gate.ls_on, 1'h1);
      $display("test pulse done");
   endtask : test_pulse
   task automatic test_overvoltage;
      flt.overvoltage_guard <= 1'b1;
      clks(8);
      watch(2 * PER);
      chk("high side held off", hs, 0);
      @(posedge tick);
      clks(10);
      flt.overvoltage_guard <= 1'b0;
      watch(28);
      chk("no restart mid cycle", hs, 0);
      wait_hs(1'b1);
      chk("restart next cycle", 16'(k < PER), 1);
      $display("test overvoltage done");
   endtask : test_overvoltage
   task automatic test_source;
      @(posedge tick);
      clks(25);
      flt.ls_source_limit <= 1'b1;
      clks(8);
      watch(2 * PER);
      chk("pulse skipped", hs, 0);
      chk("low side kept on", ls, 2 * PER);
      flt.ls_source_limit <= 1'b0;
      watch(2 * PER);
      chk("pulses resume", 16'(hs > 0), 1);
      $display("test source limit done");
   endtask : test_source
   task automatic test_sink;
      @(posedge tick);
      clks(25);
      flt.ls_sink_limit <= 1'b1;
      clks(5);
      flt.ls_sink_limit <= 1'b0;
      clks(3);
      chk("low side cut", gate, 2'h0);
      watch(5);
      chk("both off to cycle end", hs + ls, 0);
      watch(PER);
      chk("switching next cycle", 16'(hs > 0), 1);
      $display("test sink limit done");
   endtask : test_sink
   task automatic test_overload;
      flt.overload <= 1'b1;
      clks(3 * PER);
      flt.overload <= 1'b0;
      clks(PER);
      flt.overload <= 1'b1;
      clks(3 * PER);
      chk("count cleared by release", ssd, 1'h0);
      watch(4 * PER);
      chk("overload shutdown", {ssd, gate}, 3'h4);
      flt.overload <= 1'b0;
      watch(4 * PER);
      chk("held off in hiccup", hs + ls, 0);
      clks(7 * PER);
      chk("restart after hiccup", ssd, 1'h0);
      $display("test overload done");
   endtask : test_overload
   task automatic test_thermal;
      flt.over_temp <= 1'b1;
      clks(8);
      chk("switching stopped", gate, 2'h0);
      chk("good low when hot", good, 1'h0);
      watch(20 * PER);
      chk("no count while hot", hs + ls, 0);
      flt.over_temp <= 1'b0;
      watch(5 * PER);
      chk("cooling wait", hs + ls, 0);
      flt.over_temp <= 1'b1;
      clks(8);
      flt.over_temp <= 1'b0;
      watch(5 * PER);
      chk("reheat restarts count", hs + ls, 0);
      clks(8 * PER);
      chk("power up rerun", {ssd, good}, 2'h1);
      $display("test thermal done");
   endtask : test_thermal
   initial begin
      test_start();
      test_pulse();
      test_overvoltage();
      test_source();
      test_sink();
      test_overload();
      test_thermal();
      complete_run();
   end
endmodule : bpsq_bench
`default_nettype wire
